// ---- rtl/eeprom_pkg.sv ----
package eeprom_pkg;
   // ----------------------------------------
   // Array and addressing
   // ----------------------------------------
   localparam int MEM_BYTES = 8192;
   localparam int ADDR_W = 13;
   localparam int PAGE_BYTES = 32;
   localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
   localparam logic [7:0] MEM_RESET_VALUE = 8'hFF;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int WRITE_CYCLE_MS = 5;
   localparam int WRITE_CYCLE_CYC = (CLK_HZ / 1000) * WRITE_CYCLE_MS;
   // ----------------------------------------
   // Receiver states
   // ----------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_DEVADDR, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA, ST_IGNORE} link_state_t;
endpackage : eeprom_pkg

// ---- rtl/eeprom_serial_target.sv ----
// Function
// RQ1: Respond only when received strap bits match the three strapped address inputs.
// RQ2: Distinct strap combinations let up to eight devices share one bus.
// RQ3: Undriven strap or write-lock inputs count as low.
// RQ4: Data line is open drain: pull low or release only.
// RQ5: Sample commands and write data on rising clock edge.
// RQ6: Change returned data bits on falling clock edge.
// RQ7: Controller keeps the clock high while the bus is idle.
// RQ8: Write-lock high blocks every array write; low lets writes proceed. Code samples the lock only at the stop.
// RQ9: Store 8192 bytes addressed by a 13-bit byte address.
// RQ10: Accept page writes up to 32 bytes and partial pages.
// RQ11: Self-timed programming cycle of at most 5 ms after a write.
// RQ12: Support random reads and sequential reads through following bytes.
// RQ13: Work at 100 kHz, 400 kHz and 1 MHz bus clock rates.
// RQ14: Strap comparison uses the three bits above the read/write bit.
`timescale 1ns/10ps
`default_nettype none
module eeprom_serial_target #(
   parameter int WRITE_CYC = eeprom_pkg::WRITE_CYCLE_CYC
) (
   input wire logic clk, // System clock, 25 MHz
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic scl_in, // Bus clock pin level
   input wire logic sda_in, // Data pin level
   output logic sda_out, // Data pin drive value, always low
   output logic sda_oe, // High while pulling the data pin low
   input wire logic addr_strap_bit0, // Strap input 0, undriven reads low
   input wire logic addr_strap_bit1, // Strap input 1, undriven reads low
   input wire logic addr_strap_bit2, // Strap input 2, undriven reads low
   input wire logic write_lock, // High blocks writes, undriven reads low
   output logic busy // Internal write cycle in progress
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Pins pass three flops; a change counts once stages two and three agree.
   // The lag is about four clocks, well inside the shortest bus clock phase at
   // every supported rate, so the filter costs no bus speed. [RQ13]
   // Undriven pins arrive as low from the pad pull-down, so no logic is needed here. [RQ3]
   logic [2:0] scl_s, sda_s, wl_s, a0_s, a1_s, a2_s;
   logic scl_f, sda_f, wl_f, next_scl_f, next_sda_f, next_wl_f;
   logic [2:0] strap_f, next_strap_f;

   function automatic logic filt(input logic [2:0] s, input logic prev);
      filt = (s[1] == s[2]) ? s[2] : prev;
   endfunction : filt

   always_comb begin
      next_scl_f = filt(scl_s, scl_f);
      next_sda_f = filt(sda_s, sda_f);
      next_wl_f = filt(wl_s, wl_f);
      next_strap_f = {filt(a2_s, strap_f[2]), filt(a1_s, strap_f[1]), filt(a0_s, strap_f[0])};
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         wl_s <= 3'h0;
         a0_s <= 3'h0;
         a1_s <= 3'h0;
         a2_s <= 3'h0;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         wl_f <= 1'b0;
         strap_f <= 3'h0;
      end else begin
         scl_s <= {scl_s[1:0], scl_in};
         sda_s <= {sda_s[1:0], sda_in};
         wl_s <= {wl_s[1:0], write_lock};
         a0_s <= {a0_s[1:0], addr_strap_bit0};
         a1_s <= {a1_s[1:0], addr_strap_bit1};
         a2_s <= {a2_s[1:0], addr_strap_bit2};
         scl_f <= next_scl_f;
         sda_f <= next_sda_f;
         wl_f <= next_wl_f;
         strap_f <= next_strap_f;
      end
   end

   // Edge and condition detection on the filtered levels
   logic scl_rise, scl_fall, start_cond, stop_cond;
   assign scl_rise = next_scl_f & ~scl_f;
   assign scl_fall = ~next_scl_f & scl_f;
   assign start_cond = scl_f & next_scl_f & sda_f & ~next_sda_f;
   assign stop_cond = scl_f & next_scl_f & ~sda_f & next_sda_f;

   // ----------------------------------------
   // Memory and page buffer
   // ----------------------------------------
   logic [7:0] mem [eeprom_pkg::MEM_BYTES]; // [RQ9]
   logic [7:0] page_buf [eeprom_pkg::PAGE_BYTES];
   logic [eeprom_pkg::PAGE_BYTES-1:0] page_dirty, next_page_dirty;

   // ----------------------------------------
   // Protocol engine
   // ----------------------------------------
   eeprom_pkg::link_state_t state, next_state;
   logic [7:0] shreg, next_shreg;
   logic [3:0] bitcnt, next_bitcnt;
   logic ack_phase, next_ack_phase;
   logic [12:0] addr, next_addr;
   logic [12:0] page_base, next_page_base;
   logic rd_dir, next_rd_dir;
   logic drive_low, next_drive_low;
   logic [7:0] rd_byte, next_rd_byte;
   logic host_ack, next_host_ack;
   logic wr_go, next_wr_go;
   logic pb_we;
   logic [4:0] pb_idx;
   logic [7:0] pb_data;
   logic [22:0] wr_cnt, next_wr_cnt;
   logic [5:0] commit_idx, next_commit_idx;
   logic wl_at_stop, next_wl_at_stop;

   // Byte received: shreg already holds seven bits, the eighth is sda
   logic [7:0] rx_byte;
   assign rx_byte = {shreg[6:0], next_sda_f};

   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_bitcnt = bitcnt;
      next_ack_phase = ack_phase;
      next_addr = addr;
      next_page_base = page_base;
      next_rd_dir = rd_dir;
      next_drive_low = drive_low;
      next_rd_byte = rd_byte;
      next_host_ack = host_ack;
      next_page_dirty = page_dirty;
      next_wr_go = 1'b0;
      next_wl_at_stop = wl_at_stop;
      pb_we = 1'b0;
      pb_idx = addr[4:0];
      pb_data = rx_byte;
      if (start_cond) begin
         next_state = busy ? eeprom_pkg::ST_IGNORE : eeprom_pkg::ST_DEVADDR;
         next_bitcnt = 4'h0;
         next_ack_phase = 1'b0;
         next_drive_low = 1'b0;
         // A poll during the write cycle must not wipe the page that is still
         // being committed; only an accepted start opens a fresh page.
         if (!busy) begin
            next_page_dirty = '0; // [RQ11]
         end
      end else if (stop_cond) begin
         // Commit the page only when a whole data byte arrived
         if (state == eeprom_pkg::ST_WDATA && page_dirty != '0) begin
            next_wr_go = 1'b1; // [RQ11]
            next_wl_at_stop = wl_f;
         end
         next_state = eeprom_pkg::ST_IDLE;
         next_drive_low = 1'b0;
      end else if (scl_rise && state != eeprom_pkg::ST_IDLE && state != eeprom_pkg::ST_IGNORE) begin
         if (ack_phase) begin
            next_host_ack = ~next_sda_f;
         end else if (state == eeprom_pkg::ST_RDATA) begin
            next_bitcnt = bitcnt + 4'h1;
         end else begin
            next_shreg = rx_byte; // [RQ5]
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == 4'h7) begin
               case (state)
                  eeprom_pkg::ST_DEVADDR: begin
                     // Strap field sits just above the direction bit [RQ14]
                     if (rx_byte[7:4] == eeprom_pkg::DEV_TYPE_CODE && rx_byte[3:1] == strap_f) begin // [RQ1] [RQ2]
                        next_rd_dir = rx_byte[0];
                     end else begin
                        next_state = eeprom_pkg::ST_IGNORE;
                     end
                  end
                  eeprom_pkg::ST_ADDR_HI: next_addr = {rx_byte[4:0], addr[7:0]};
                  eeprom_pkg::ST_ADDR_LO: begin
                     next_addr = {addr[12:8], rx_byte};
                     next_page_base = {addr[12:8], rx_byte[7:5], 5'h00};
                  end
                  eeprom_pkg::ST_WDATA: begin
                     // Address rolls over inside the page [RQ10]
                     pb_we = 1'b1;
                     next_page_dirty[addr[4:0]] = 1'b1;
                     next_addr = {addr[12:5], addr[4:0] + 5'h01};
                  end
                  default: next_state = state;
               endcase
            end
         end
      end else if (scl_fall && state != eeprom_pkg::ST_IDLE && state != eeprom_pkg::ST_IGNORE) begin
         if (ack_phase) begin
            // Acknowledge slot over: release and move on
            next_ack_phase = 1'b0;
            next_bitcnt = 4'h0;
            next_drive_low = 1'b0;
            case (state)
               eeprom_pkg::ST_DEVADDR: next_state = rd_dir ? eeprom_pkg::ST_RDATA : eeprom_pkg::ST_ADDR_HI;
               eeprom_pkg::ST_ADDR_HI: next_state = eeprom_pkg::ST_ADDR_LO;
               eeprom_pkg::ST_ADDR_LO: next_state = eeprom_pkg::ST_WDATA;
               eeprom_pkg::ST_RDATA: next_state = host_ack ? eeprom_pkg::ST_RDATA : eeprom_pkg::ST_IGNORE;
               default: next_state = state;
            endcase
            if (state == eeprom_pkg::ST_DEVADDR && rd_dir) begin
               next_rd_byte = mem[addr];
               next_drive_low = ~mem[addr][7]; // [RQ6]
            end else if (state == eeprom_pkg::ST_RDATA && host_ack) begin
               next_rd_byte = mem[addr];
               next_drive_low = ~mem[addr][7]; // [RQ6] [RQ12]
            end
         end else if (bitcnt == 4'h8) begin
            if (state == eeprom_pkg::ST_RDATA) begin
               // Release for controller acknowledge; advance to next byte
               next_drive_low = 1'b0;
               next_addr = addr + 13'h0001; // [RQ12]
            end else begin
               next_drive_low = 1'b1; // [RQ4]
            end
            next_ack_phase = 1'b1;
         end else if (state == eeprom_pkg::ST_RDATA) begin
            next_drive_low = ~rd_byte[3'(7 - bitcnt)]; // [RQ6]
         end
      end
   end

   // ----------------------------------------
   // Self-timed write cycle
   // ----------------------------------------
   // One array byte per clock, then wait out the rest of the cycle.
   always_comb begin
      next_wr_cnt = wr_cnt;
      next_commit_idx = commit_idx;
      if (wr_go) begin
         next_wr_cnt = 23'(WRITE_CYC); // [RQ11]
         next_commit_idx = 6'h00;
      end else if (wr_cnt != 23'h0) begin
         next_wr_cnt = wr_cnt - 23'h1;
         if (commit_idx != 6'(eeprom_pkg::PAGE_BYTES)) begin
            next_commit_idx = commit_idx + 6'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= eeprom_pkg::ST_IDLE;
         shreg <= 8'h00;
         bitcnt <= 4'h0;
         ack_phase <= 1'b0;
         addr <= 13'h0000;
         page_base <= 13'h0000;
         rd_dir <= 1'b0;
         drive_low <= 1'b0;
         rd_byte <= 8'h00;
         host_ack <= 1'b0;
         page_dirty <= '0;
         wr_go <= 1'b0;
         wr_cnt <= 23'h0;
         commit_idx <= 6'h00;
         wl_at_stop <= 1'b0;
         sda_oe <= 1'b0;
         busy <= 1'b0;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         bitcnt <= next_bitcnt;
         ack_phase <= next_ack_phase;
         addr <= next_addr;
         page_base <= next_page_base;
         rd_dir <= next_rd_dir;
         drive_low <= next_drive_low;
         rd_byte <= next_rd_byte;
         host_ack <= next_host_ack;
         page_dirty <= next_page_dirty;
         wr_go <= next_wr_go;
         wr_cnt <= next_wr_cnt;
         commit_idx <= next_commit_idx;
         wl_at_stop <= next_wl_at_stop;
         sda_oe <= next_drive_low; // [RQ4]
         busy <= wr_go | (next_wr_cnt != 23'h0);
      end
   end

   // Open drain: the driven value is always low [RQ4]
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // Array and page storage carry no reset, as in a real non-volatile part
   always_ff @(posedge clk) begin
      if (pb_we) begin
         page_buf[pb_idx] <= pb_data;
      end
      if (wr_cnt != 23'h0 && commit_idx < 6'(eeprom_pkg::PAGE_BYTES) && !wl_at_stop
          && page_dirty[commit_idx[4:0]]) begin // [RQ8]
         mem[{page_base[12:5], commit_idx[4:0]}] <= page_buf[commit_idx[4:0]];
      end
   end
endmodule : eeprom_serial_target
`default_nettype wire

// ---- testbench/serial_target_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module serial_target_properties #(
   parameter int WRITE_CYC = 200
) (
   input wire logic clk, // System clock
   input wire logic reset_n, // Async reset, active low
   input wire logic scl_in, // Bus clock pin
   input wire logic sda_in, // Resolved data line
   input wire logic sda_out, // Data drive value
   input wire logic sda_oe, // Data pull enable
   input wire logic addr_strap_bit0, // Strap 0
   input wire logic addr_strap_bit1, // Strap 1
   input wire logic addr_strap_bit2, // Strap 2
   input wire logic write_lock, // Write lock
   input wire logic busy // Write cycle running
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   int busy_cnt;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= busy ? busy_cnt + 1 : 0;
      end
   end
   // The filtered clock lags the pin by some cycles, so look back past the fall
   sequence after_fall;
      !$past(scl_in, 2) && $past(scl_in, 6);
   endsequence
   sequence held_high;
      $stable(sda_oe) [*3];
   endsequence
   out_low_a: assert property (!sda_out) else $error("data drive value not low");
   wire_low_a: assert property (sda_oe |-> !sda_in) else $error("pulled line not low");
   edge_after_fall_a: assert property ($changed(sda_oe) |-> after_fall) else $error("data moved off a fall");
   hold_high_a: assert property ($rose(scl_in) |=> held_high) else $error("data moved while clock high");
   ack_width_a: assert property ($rose(sda_oe) |-> sda_oe [*8]) else $error("low bit shorter than a bit");
   busy_bound_a: assert property (busy_cnt <= WRITE_CYC) else $error("write cycle too long");
   busy_quiet_a: assert property (busy |-> !sda_oe) else $error("answered during write cycle");
   busy_after_stop_a: assert property ($rose(busy) |-> scl_in && sda_in) else $error("write cycle not after stop");
endmodule : serial_target_properties
`default_nettype wire

// ---- testbench/bus_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module bus_ctrl_model (
   input wire logic clk, // Bench clock, times bus phases
   input wire logic sda_wire, // Resolved data line
   output logic scl, // Bus clock, high while idle
   output logic sda_low // High while pulling data low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   // One bit is 8 cycles (320 ns): low 5, high 3; data moves only while low
   task automatic bit_io(input logic b, output logic r);
      scl = 1'b0;
      tick(3);
      sda_low = !b;
      tick(2);
      scl = 1'b1;
      tick(2);
      r = sda_wire;
      tick(1);
   endtask : bit_io
   task automatic start();
      logic r;
      bit_io(1'b1, r);
      sda_low = 1'b1;
      tick(3);
   endtask : start
   task automatic stop();
      logic r;
      bit_io(1'b0, r);
      sda_low = 1'b0;
      tick(8);
   endtask : stop
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask : wbyte
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(nack, r);
   endtask : rbyte
endmodule : bus_ctrl_model
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int WCYC = 200;
   logic clk, reset_n, sda_oe, sda_out, busy, lock, scl, ctl_low, sda_wire;
   logic [2:0] strap;
   int n_fail, cmp_count;
   assign sda_wire = !(ctl_low || (sda_oe && !sda_out));
   eeprom_serial_target #(.WRITE_CYC(WCYC)) uut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
      .addr_strap_bit2(strap[2]), .write_lock(lock), .busy(busy));
   bus_ctrl_model ctl (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(ctl_low));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   task automatic expect_eq(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : expect_eq
   task automatic expect_bit(input logic got, input logic exp, input string what);
      expect_eq({7'h00, got}, {7'h00, exp}, what);
   endtask : expect_bit
   task automatic select(input logic [2:0] s, input logic rd, output logic ack);
      ctl.start();
      ctl.wbyte({eeprom_pkg::DEV_TYPE_CODE, s, rd}, ack);
   endtask : select
   task automatic set_addr(input logic [12:0] a);
      logic ack;
      select(strap, 1'b0, ack);
      expect_bit(ack, 1'b1, "select ack");
      ctl.wbyte({3'h0, a[12:8]}, ack);
      ctl.wbyte(a[7:0], ack);
   endtask : set_addr
   task automatic write_bytes(input logic [12:0] a, input logic [7:0] d[$]);
      logic ack;
      set_addr(a);
      foreach (d[i]) ctl.wbyte(d[i], ack);
      ctl.stop();
   endtask : write_bytes
   task automatic read_check(input logic [12:0] a, input logic [7:0] e[$]);
      logic ack;
      logic [7:0] d;
      set_addr(a);
      select(strap, 1'b1, ack);
      foreach (e[i]) begin
         ctl.rbyte(i == e.size() - 1, d);
         expect_eq(d, e[i], "read data");
      end
      ctl.stop();
   endtask : read_check
   task automatic wait_idle();
      int k;
      k = 0;
      while (busy !== 1'b0 && k < WCYC + 20) begin
         @(negedge clk);
         k++;
      end
      expect_bit(busy, 1'b0, "write cycle end");
      if (busy !== 1'b0) tally_and_finish();
   endtask : wait_idle
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   logic [2:0] strap_set[2] = '{3'h5, 3'h2};
   task automatic s_strap();
      logic ack;
      foreach (strap_set[j]) begin
         strap = strap_set[j];
         for (int s = 0; s < 8; s++) begin
            select(3'(s), 1'b0, ack);
            ctl.stop();
            expect_bit(ack, (3'(s) == strap), "strap match");
            wait_idle();
         end
      end
   endtask : s_strap
   task automatic s_page();
      logic ack;
      write_bytes(13'h1FFE, '{8'h11, 8'h22, 8'h33});
      select(strap, 1'b0, ack);
      ctl.stop();
      expect_bit(ack, 1'b0, "poll while busy");
      wait_idle();
      read_check(13'h1FFE, '{8'h11, 8'h22});
      read_check(13'h1FE0, '{8'h33});
   endtask : s_page
   task automatic s_lock();
      write_bytes(13'h0100, '{8'h3C});
      wait_idle();
      lock = 1'b1;
      write_bytes(13'h0100, '{8'hC3});
      wait_idle();
      lock = 1'b0;
      read_check(13'h0100, '{8'h3C});
   endtask : s_lock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      reset_n = 1'b0;
      strap = 3'h5;
      lock = 1'b0;
      n_fail = 0;
      cmp_count = 0;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      s_strap();
      s_page();
      s_lock();
      tally_and_finish();
   end
   initial begin
      repeat (90000) @(negedge clk);
      n_fail++;
      tally_and_finish();
   end
endmodule : tb
bind eeprom_serial_target serial_target_properties #(.WRITE_CYC(WRITE_CYC)) chk (.clk(clk), .reset_n(reset_n),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(addr_strap_bit0),
   .addr_strap_bit1(addr_strap_bit1), .addr_strap_bit2(addr_strap_bit2), .write_lock(write_lock), .busy(busy));
`default_nettype wire
